// file: src/cpu_bus_cfg.svh
`ifndef CPU_BUS_CFG_SVH
`define CPU_BUS_CFG_SVH

// each processor clock is split into a high phase and a low phase of core_clk
`define PHASE_HIGH 1'h0
`define PHASE_LOW 1'h1
`define NMI_VECTOR_TYPE 8'h02
`define RESET_MIN_CLOCKS 4
`define STROBE_IDLE_N 1'h1
`define VECTOR_RESET 8'h00

`endif

// file: src/cpu_bus_pkg.sv
package cpu_bus_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_T1 = 7'h02,
    ST_T2 = 7'h04,
    ST_T3 = 7'h08,
    ST_TW = 7'h10,
    ST_T4 = 7'h20,
    ST_HOLD = 7'h40
  } bus_state_t;

  typedef enum logic [2:0] {
    KIND_MEM_READ = 3'h0,
    KIND_MEM_WRITE = 3'h1,
    KIND_IO_READ = 3'h2,
    KIND_IO_WRITE = 3'h3,
    KIND_IRQ_ACK = 3'h4
  } bus_kind_t;

endpackage

// file: src/sync_two_flop.sv
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // refused while elaborating, so a bad width never reaches a netlist
  if (WIDTH < 1) begin : g_width_check
    $error("sync_two_flop needs WIDTH of at least 1");
  end

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// file: src/cpu_min_mode_bus_control.sv
`timescale 1ns/1ps
`default_nettype none

`include "cpu_bus_cfg.svh"

module cpu_min_mode_bus_control
  import cpu_bus_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // pins from the system
  input wire logic wait_test_n,
  input wire logic nmi_in,
  input wire logic reset_in,
  input wire logic system_mode_select,
  input wire logic maskable_irq_request,
  input wire logic ready,
  input wire logic hold_req,
  // core side
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic wait_instr,
  input wire logic instr_last,
  input wire logic irq_enable,
  output logic req_taken,
  output logic cycle_done,
  output logic wait_release,
  output logic nmi_take,
  output logic irq_take,
  output logic [7:0] vector_type,
  output logic core_reset,
  // bus control pins
  output logic mem_io_sel,
  output logic mem_io_sel_oe,
  output logic write_strobe_n,
  output logic write_strobe_oe,
  output logic read_strobe_n,
  output logic read_strobe_oe,
  output logic xcvr_direction,
  output logic xcvr_direction_oe,
  output logic xcvr_enable_n,
  output logic xcvr_enable_oe,
  output logic irq_ack_strobe_n,
  output logic addr_latch_strobe,
  output logic bus_hold_grant
);

  logic test_n_s;
  logic nmi_s;
  logic reset_s;
  logic mode_s;
  logic irq_s;

  // ready and hold are expected to meet setup on their own; they are used raw
  sync_two_flop #(.WIDTH(5)) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({wait_test_n, nmi_in, reset_in, system_mode_select, maskable_irq_request}),
    .sync_out({test_n_s, nmi_s, reset_s, mode_s, irq_s})
  );

  bus_state_t state_q;
  bus_state_t state_d;
  logic phase_q;
  bus_kind_t kind_q;
  logic nmi_prev_q;
  logic nmi_pend_q;
  logic min_mode;
  logic phase_end;
  logic start_cycle;
  logic hold_now;

  function automatic logic kind_is_write(input bus_kind_t k);
    kind_is_write = (k == KIND_MEM_WRITE) || (k == KIND_IO_WRITE);
  endfunction

  function automatic logic kind_is_read(input bus_kind_t k);
    kind_is_read = (k == KIND_MEM_READ) || (k == KIND_IO_READ);
  endfunction

  function automatic logic kind_is_mem(input bus_kind_t k);
    kind_is_mem = (k == KIND_MEM_READ) || (k == KIND_MEM_WRITE);
  endfunction

  assign min_mode = mode_s;
  assign phase_end = (phase_q == `PHASE_LOW);
  // idle clocks are where a new cycle may begin; a hold may begin there or in t4
  assign start_cycle = (state_q == ST_IDLE) && phase_end && req_valid && min_mode && !hold_req;
  // grant is issued at the middle of a t4 or idle clock
  assign hold_now = ((state_q == ST_IDLE) || (state_q == ST_T4)) && (phase_q == `PHASE_HIGH) && hold_req;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_cycle) begin
          state_d = ST_T1;
        end
      end
      ST_T1: begin
        if (phase_end) begin
          state_d = ST_T2;
        end
      end
      ST_T2: begin
        if (phase_end) begin
          state_d = ST_T3;
        end
      end
      ST_T3, ST_TW: begin
        if (phase_end) begin
          state_d = ready ? ST_T4 : ST_TW;
        end
      end
      ST_T4: begin
        if (phase_end) begin
          state_d = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (!hold_req) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (hold_now) begin
      state_d = ST_HOLD;
    end
  end

  // a synchronised reset drops the bus cycle in flight at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      phase_q <= `PHASE_HIGH;
    end else if (reset_s) begin
      state_q <= ST_IDLE;
      phase_q <= `PHASE_HIGH;
    end else if (hold_now) begin
      state_q <= state_d;
      phase_q <= `PHASE_LOW;
    end else begin
      state_q <= state_d;
      phase_q <= (state_q == ST_HOLD) ? `PHASE_HIGH : ~phase_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      kind_q <= KIND_MEM_READ;
      req_taken <= 1'h0;
      cycle_done <= 1'h0;
    end else begin
      req_taken <= start_cycle && !reset_s;
      // a grant in mid-t4 still closes the cycle, so the core is never left waiting
      cycle_done <= (state_q == ST_T4) && (phase_end || hold_now) && !reset_s;
      if (start_cycle) begin
        kind_q <= bus_kind_t'(req_kind);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_reset <= 1'h1;
    end else begin
      core_reset <= reset_s;
    end
  end

  // the wait test is looked at only at the middle of each processor clock, at the end of its high phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_release <= 1'h0;
    end else begin
      wait_release <= wait_instr && !test_n_s && (phase_q == `PHASE_HIGH) && !reset_s;
    end
  end

  // pending nmi: a fresh edge wins over the clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_prev_q <= 1'h0;
      nmi_pend_q <= 1'h0;
    end else if (reset_s) begin
      nmi_prev_q <= nmi_s;
      nmi_pend_q <= 1'h0;
    end else begin
      nmi_prev_q <= nmi_s;
      if (nmi_s && !nmi_prev_q) begin
        nmi_pend_q <= 1'h1;
      end else if (instr_last) begin
        nmi_pend_q <= 1'h0;
      end
    end
  end

  // nmi outranks the maskable request; irq_enable has no say over nmi
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_take <= 1'h0;
      irq_take <= 1'h0;
      vector_type <= `VECTOR_RESET;
    end else begin
      nmi_take <= instr_last && nmi_pend_q && !reset_s;
      irq_take <= instr_last && !nmi_pend_q && irq_s && irq_enable && !reset_s;
      if (instr_last && nmi_pend_q) begin
        vector_type <= `NMI_VECTOR_TYPE;
      end
    end
  end

  logic in_cycle;
  logic in_strobe;
  logic late_strobe;
  logic den_read;
  logic den_write;

  assign in_cycle = (state_q == ST_T1) || (state_q == ST_T2) || (state_q == ST_T3) ||
                    (state_q == ST_TW) || (state_q == ST_T4);
  assign in_strobe = (state_q == ST_T2) || (state_q == ST_T3) || (state_q == ST_TW);
  // read-type strobes wait out the first half of t2 so the address is off the bus
  assign late_strobe = ((state_q == ST_T2) && phase_end) || (state_q == ST_T3) || (state_q == ST_TW);
  assign den_read = late_strobe || ((state_q == ST_T4) && !phase_end);
  assign den_write = in_strobe || ((state_q == ST_T4) && !phase_end);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_latch_strobe <= 1'h0;
    end else begin
      addr_latch_strobe <= (state_q == ST_T1) && phase_end && !reset_s;
    end
  end

  // status lines are set in the idle clock before t1 and kept through t4
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_io_sel <= 1'h1;
      xcvr_direction <= 1'h1;
    end else if (state_q == ST_HOLD || reset_s) begin
      mem_io_sel <= 1'h1;
      xcvr_direction <= 1'h1;
    end else if (start_cycle) begin
      mem_io_sel <= kind_is_mem(bus_kind_t'(req_kind));
      xcvr_direction <= kind_is_write(bus_kind_t'(req_kind));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_strobe_n <= `STROBE_IDLE_N;
      read_strobe_n <= `STROBE_IDLE_N;
      irq_ack_strobe_n <= `STROBE_IDLE_N;
    end else if (reset_s) begin
      write_strobe_n <= `STROBE_IDLE_N;
      read_strobe_n <= `STROBE_IDLE_N;
      irq_ack_strobe_n <= `STROBE_IDLE_N;
    end else begin
      write_strobe_n <= !(in_strobe && kind_is_write(kind_q));
      read_strobe_n <= !(late_strobe && kind_is_read(kind_q));
      irq_ack_strobe_n <= !(late_strobe && (kind_q == KIND_IRQ_ACK));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xcvr_enable_n <= `STROBE_IDLE_N;
    end else if (reset_s || !in_cycle) begin
      xcvr_enable_n <= `STROBE_IDLE_N;
    end else if (kind_is_write(kind_q)) begin
      xcvr_enable_n <= !den_write;
    end else begin
      xcvr_enable_n <= !den_read;
    end
  end

  // floated lines rest at one through the outside pull-ups
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_hold_grant <= 1'h0;
      mem_io_sel_oe <= 1'h0;
      write_strobe_oe <= 1'h0;
      read_strobe_oe <= 1'h0;
      xcvr_direction_oe <= 1'h0;
      xcvr_enable_oe <= 1'h0;
    end else begin
      bus_hold_grant <= (state_d == ST_HOLD) && !reset_s;
      mem_io_sel_oe <= (state_d != ST_HOLD) && min_mode;
      write_strobe_oe <= (state_d != ST_HOLD) && min_mode;
      read_strobe_oe <= (state_d != ST_HOLD) && min_mode;
      xcvr_direction_oe <= (state_d != ST_HOLD) && min_mode;
      xcvr_enable_oe <= (state_d != ST_HOLD) && min_mode;
    end
  end

endmodule

`default_nettype wire

// file: tb/bus_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

module bus_partner_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] wait_ts,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic irq_ack_strobe_n,
  output logic ready
);
  logic [3:0] cnt_q;
  logic busy;
  assign busy = !(write_strobe_n && read_strobe_n && irq_ack_strobe_n);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 4'h0;
    else cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
  end
  // not ready while idle either: a slow slave gives no early grant
  assign ready = busy && (cnt_q >= {1'h0, wait_ts, 1'h1});
endmodule

`default_nettype wire

// file: tb/cpu_min_mode_bus_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module bus_ctl_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_in,
  input wire logic hold_req,
  input wire logic wait_instr,
  input wire logic req_taken,
  input wire logic wait_release,
  input wire logic nmi_take,
  input wire logic [7:0] vector_type,
  input wire logic core_reset,
  input wire logic mem_io_sel,
  input wire logic mem_io_sel_oe,
  input wire logic write_strobe_n,
  input wire logic write_strobe_oe,
  input wire logic read_strobe_n,
  input wire logic read_strobe_oe,
  input wire logic xcvr_direction,
  input wire logic xcvr_direction_oe,
  input wire logic xcvr_enable_n,
  input wire logic xcvr_enable_oe,
  input wire logic irq_ack_strobe_n,
  input wire logic addr_latch_strobe,
  input wire logic bus_hold_grant
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ale_pulse_a: assert property (addr_latch_strobe |=> !addr_latch_strobe)
    else $error("latch strobe too long");
  ale_after_take_a: assert property (req_taken |-> ##2 addr_latch_strobe)
    else $error("latch strobe missing");
  write_den_a: assert property (!write_strobe_n && write_strobe_oe |-> !xcvr_enable_n && xcvr_direction)
    else $error("write without enable");
  read_den_a: assert property (!read_strobe_n && read_strobe_oe |-> !xcvr_enable_n && !xcvr_direction)
    else $error("read without enable");
  ack_den_a: assert property (!irq_ack_strobe_n |-> !xcvr_enable_n && !xcvr_direction)
    else $error("ack without enable");
  hold_float_a: assert property (bus_hold_grant |-> !(mem_io_sel_oe || write_strobe_oe ||
    xcvr_direction_oe || xcvr_enable_oe))
    else $error("lines driven in hold");
  grant_cause_a: assert property ($rose(bus_hold_grant) |-> $past(hold_req))
    else $error("grant without request");
  sel_stable_a: assert property (!write_strobe_n && write_strobe_oe |=> $stable(mem_io_sel))
    else $error("select moved in cycle");
  nmi_vector_a: assert property (nmi_take |=> vector_type == 8'h02)
    else $error("wrong nmi vector");
  wait_cause_a: assert property (wait_release |-> $past(wait_instr))
    else $error("release without wait");
  reset_sync_a: assert property (reset_in [*4] |-> ##[0:1] core_reset)
    else $error("reset not taken");
  reset_quiet_a: assert property (core_reset |-> write_strobe_n && read_strobe_n && irq_ack_strobe_n)
    else $error("strobe active in reset");
  cover property (req_taken);
  cover property ($rose(bus_hold_grant));
  cover property (nmi_take);
endmodule

bind cpu_min_mode_bus_control bus_ctl_checker chk (.*);

`default_nettype wire

// file: tb/tb_cpu_min_mode_bus_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_min_mode_bus_control;
  import cpu_bus_pkg::*;
  logic core_clk = 1'h0, rst_n = 1'h0, wait_test_n = 1'h1, nmi_in = 1'h0, reset_in = 1'h0, hold_req = 1'h0;
  logic system_mode_select = 1'h1, maskable_irq_request = 1'h0, req_valid = 1'h0;
  logic wait_instr = 1'h0, instr_last = 1'h0, irq_enable = 1'h0;
  logic [2:0] req_kind = 3'h0;
  logic [1:0] wait_ts = 2'h0;
  logic ready, req_taken, cycle_done, wait_release, nmi_take, irq_take, core_reset;
  logic mem_io_sel, mem_io_sel_oe, write_strobe_n, write_strobe_oe, read_strobe_n, read_strobe_oe;
  logic xcvr_direction, xcvr_direction_oe, xcvr_enable_n, xcvr_enable_oe, irq_ack_strobe_n;
  logic addr_latch_strobe, bus_hold_grant;
  logic [7:0] vector_type;
  logic [4:0] exp_q[$];
  logic [4:0] obs = 5'h1f;
  int n_errors = 0, cmp_count = 0, cyc = 0, i;

  cpu_min_mode_bus_control dut (.*);
  bus_partner_model mem (.*);

  // one t-state is two clocks here, so its high and low phases come from the design's phase bit, one clock each
  initial forever #25 core_clk = ~core_clk;

  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task end_sim;
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task step_until(input int n, input logic [7:0] sel);
    for (i = 0; i < n; i++) begin
      if ((sel == 8'h0 && req_taken) || (sel == 8'h1 && cycle_done) || (sel == 8'h2 && nmi_take) ||
          (sel == 8'h3 && irq_take) || (sel == 8'h4 && wait_release) || (sel == 8'h5 && bus_hold_grant) ||
          (sel == 8'h6 && !bus_hold_grant) || (sel == 8'h7 && !core_reset)) break;
      @(negedge core_clk);
    end
  endtask

  // flags are active low: a strobe seen low clears its bit
  task bus(input logic [2:0] k);
    wait_ts = 2'($urandom % 3);
    req_kind = k;
    req_valid = 1'h1;
    exp_q.push_back({k < 3'h2, k[0], !k[0], k[0] || k[2], k != 3'h4});
    step_until(40, 8'h0);
    req_valid = 1'h0;
    step_until(80, 8'h1);
    repeat (3) @(negedge core_clk);
  endtask

  always @(negedge core_clk) begin
    if (req_taken) obs = {mem_io_sel, xcvr_direction, 3'h7};
    obs[2:0] = obs[2:0] & {write_strobe_n, read_strobe_n, irq_ack_strobe_n};
    if (cycle_done && exp_q.size() > 0) check({3'h0, obs}, {3'h0, exp_q.pop_front()}, "cycle");
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      end_sim;
    end
  end

  initial begin
    void'($urandom(32'hd980b489));
    repeat (10) @(negedge core_clk);
    rst_n = 1'h1;
    repeat (4) @(negedge core_clk);
    for (int r = 0; r < 3; r++) for (int k = 0; k < 5; k++) bus(3'(k));
    nmi_in = 1'h1;
    repeat (4) @(negedge core_clk);
    instr_last = 1'h1;
    step_until(8, 8'h2);
    check(nmi_take, 8'h01, "nmi_take");
    instr_last = 1'h0;
    nmi_in = 1'h0;
    @(negedge core_clk);
    check(vector_type, 8'h02, "vector_type");
    maskable_irq_request = 1'h1;
    instr_last = 1'h1;
    for (int m = 0; m < 6; m++) begin
      @(negedge core_clk);
      check(irq_take, 8'h00, "masked irq_take");
    end
    irq_enable = 1'h1;
    step_until(8, 8'h3);
    check(irq_take, 8'h01, "irq_take");
    {irq_enable, instr_last, maskable_irq_request} = 3'h0;
    wait_instr = 1'h1;
    for (int m = 0; m < 6; m++) begin
      @(negedge core_clk);
      check(wait_release, 8'h00, "held wait_release");
    end
    wait_test_n = 1'h0;
    step_until(8, 8'h4);
    check(wait_release, 8'h01, "wait_release");
    wait_instr = 1'h0;
    wait_test_n = 1'h1;
    hold_req = 1'h1;
    step_until(12, 8'h5);
    check(bus_hold_grant, 8'h01, "bus_hold_grant");
    check({mem_io_sel_oe, write_strobe_oe, read_strobe_oe, xcvr_direction_oe, xcvr_enable_oe}, 8'h00, "oe");
    hold_req = 1'h0;
    step_until(8, 8'h6);
    check(bus_hold_grant, 8'h00, "grant release");
    check({mem_io_sel_oe, write_strobe_oe, read_strobe_oe, xcvr_direction_oe, xcvr_enable_oe}, 8'h1f, "oe back");
    // mode pin drops before the request so the synchroniser cannot let one slip through
    system_mode_select = 1'h0;
    repeat (4) @(negedge core_clk);
    check({mem_io_sel_oe, write_strobe_oe, read_strobe_oe, xcvr_direction_oe, xcvr_enable_oe}, 8'h00, "max mode oe");
    req_kind = 3'h0;
    req_valid = 1'h1;
    step_until(8, 8'h0);
    check(req_taken, 8'h00, "max mode take");
    req_valid = 1'h0;
    system_mode_select = 1'h1;
    repeat (4) @(negedge core_clk);
    bus(3'h3);
    // reset lands in the middle of a write cycle
    req_kind = 3'h1;
    req_valid = 1'h1;
    step_until(40, 8'h0);
    req_valid = 1'h0;
    repeat (4) @(negedge core_clk);
    reset_in = 1'h1;
    repeat (4) @(negedge core_clk);
    check(core_reset, 8'h01, "core_reset");
    check({write_strobe_n, xcvr_enable_n}, 8'h03, "abandoned cycle");
    reset_in = 1'h0;
    step_until(10, 8'h7);
    check(core_reset, 8'h00, "core_reset release");
    bus(3'h0);
    check(8'(exp_q.size()), 8'h00, "pending cycles");
    end_sim;
  end
endmodule

`default_nettype wire
